// ==== rtl/wcat_top.sv ====
// channel access timing: ifs timers, backoff engines, tsf, nav, sleep timer
`timescale 1ns/10ps
module wcat_top #(
    parameter int unsigned NUM_AC    = wcat_pkg::NUM_AC,
    parameter int unsigned US_CYCLES = wcat_pkg::US_CYCLES
) (
    input  wire logic                        CLK_I,
    input  wire logic                        NRST_I,
    input  wire logic                        PHY_BUSY_I,
    input  wire logic [wcat_pkg::IFS_W-1:0]  IFS_SHORT_I,
    input  wire logic [wcat_pkg::IFS_W-1:0]  IFS_REDUCED_I,
    input  wire logic                        IFS_SEL_REDUCED_I,
    input  wire logic                        TX_SCHED_I,
    output logic                             TX_START_O,
    input  wire logic [wcat_pkg::SLOT_W-1:0] SLOT_CYCLES_I,
    input  wire logic [NUM_AC-1:0]           BO_LOAD_I,
    input  wire logic [wcat_pkg::BO_W-1:0]   BO_VALUE_I,
    input  wire logic [1:0]                  ARB_POLICY_I,
    input  wire logic [NUM_AC-1:0]           ARB_FIXED_PRI_I,
    output logic [NUM_AC-1:0]                BO_GRANT_O,
    input  wire logic                        SLOW_TICK_I,
    input  wire logic                        SLEEP_REQ_I,
    input  wire logic [wcat_pkg::SLEEP_W-1:0] SLEEP_COUNT_I,
    output logic                             MAC_CLK_EN_O,
    output logic                             WAKE_O,
    input  wire logic                        TSF_LOAD_I,
    input  wire logic [wcat_pkg::TSF_W-1:0]  TSF_VALUE_I,
    output logic [wcat_pkg::TSF_W-1:0]       TSF_O,
    input  wire logic [wcat_pkg::TSF_W-1:0]  TBTT_I,
    output logic                             TBTT_O,
    input  wire logic [wcat_pkg::TSF_W-1:0]  TRIG_OFS0_I,
    input  wire logic [wcat_pkg::TSF_W-1:0]  TRIG_OFS1_I,
    output logic [wcat_pkg::NUM_TRIG-1:0]    TRIG_O,
    input  wire logic                        NAV_LOAD_I,
    input  wire logic [wcat_pkg::NAV_W-1:0]  NAV_DUR_I,
    output logic                             NAV_BUSY_O
);
    // the microsecond divider is eight bits and the round-robin pointer three
    if (NUM_AC < 1 || NUM_AC > 8 || US_CYCLES < 1 || US_CYCLES > 256)
    begin : g_bad
        $error("wcat_top: unsupported parameter values");
    end

    logic [7:0] us_cnt_r, us_cnt_nxt;
    logic       us_tick;
    logic [wcat_pkg::TSF_W-1:0] tsf_r, tsf_nxt;
    logic [wcat_pkg::NAV_W-1:0] nav_r, nav_nxt;
    logic       tbtt_r, tbtt_nxt;
    logic [wcat_pkg::NUM_TRIG-1:0] trig_r, trig_nxt;
    logic       medium_busy;

    // a shared microsecond tick keeps nav and tsf on the same time base
    always_comb begin
        us_tick    = (us_cnt_r == 8'(US_CYCLES - 1));
        us_cnt_nxt = us_tick ? 8'h00 : us_cnt_r + 8'h01;
        tsf_nxt    = us_tick ? tsf_r + 64'h1 : tsf_r;
        if (TSF_LOAD_I) begin
            tsf_nxt = TSF_VALUE_I;
        end
        nav_nxt = nav_r;
        if (NAV_LOAD_I && NAV_DUR_I > nav_r) begin
            nav_nxt = NAV_DUR_I;
        end else if (us_tick && nav_r != '0) begin
            nav_nxt = nav_r - 16'h1;
        end
        tbtt_nxt = (tsf_r == TBTT_I) && us_tick;
        trig_nxt[0] = (tsf_r == TRIG_OFS0_I) && us_tick;
        trig_nxt[1] = (tsf_r == TRIG_OFS1_I) && us_tick;
        medium_busy = PHY_BUSY_I || (nav_r != '0);
    end

    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            us_cnt_r <= 8'h00;
            tsf_r    <= '0;
            nav_r    <= '0;
            tbtt_r   <= 1'b0;
            trig_r   <= '0;
        end else begin
            us_cnt_r <= us_cnt_nxt;
            tsf_r    <= tsf_nxt;
            nav_r    <= nav_nxt;
            tbtt_r   <= tbtt_nxt;
            trig_r   <= trig_nxt;
        end
    end

    assign TSF_O      = tsf_r;
    assign TBTT_O     = tbtt_r;
    assign TRIG_O     = trig_r;
    assign NAV_BUSY_O = nav_r != '0;

    // ifs timer
    wcat_pkg::wcat_ifs_st_t ifs_st_r, ifs_st_nxt;
    logic [wcat_pkg::IFS_W-1:0] ifs_cnt_r, ifs_cnt_nxt;
    logic sched_r, sched_nxt;
    logic tx_start;

    always_comb begin
        ifs_st_nxt  = ifs_st_r;
        ifs_cnt_nxt = ifs_cnt_r;
        tx_start    = 1'b0;
        sched_nxt   = sched_r | TX_SCHED_I;
        case (ifs_st_r)
            wcat_pkg::WCAT_IFS_IDLE: begin
                if (medium_busy) begin
                    ifs_st_nxt = wcat_pkg::WCAT_IFS_BUSY;
                end
            end
            wcat_pkg::WCAT_IFS_BUSY: begin
                if (!medium_busy) begin
                    ifs_st_nxt  = wcat_pkg::WCAT_IFS_COUNT;
                    ifs_cnt_nxt = IFS_SEL_REDUCED_I ? IFS_REDUCED_I
                                                    : IFS_SHORT_I;
                end
            end
            wcat_pkg::WCAT_IFS_COUNT: begin
                if (medium_busy) begin
                    ifs_st_nxt = wcat_pkg::WCAT_IFS_BUSY;
                end else if (ifs_cnt_r <= 16'h1) begin
                    ifs_st_nxt = wcat_pkg::WCAT_IFS_DONE;
                end else begin
                    ifs_cnt_nxt = ifs_cnt_r - 16'h1;
                end
            end
            wcat_pkg::WCAT_IFS_DONE: begin
                // holds until a scheduled frame consumes the trigger or the medium turns busy again
                if (medium_busy) begin
                    ifs_st_nxt = wcat_pkg::WCAT_IFS_BUSY;
                end else if (sched_r || TX_SCHED_I) begin
                    tx_start   = 1'b1;
                    sched_nxt  = 1'b0;
                    ifs_st_nxt = wcat_pkg::WCAT_IFS_IDLE;
                end
            end
            default: ifs_st_nxt = wcat_pkg::WCAT_IFS_IDLE;
        endcase
    end

    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            ifs_st_r  <= wcat_pkg::WCAT_IFS_IDLE;
            ifs_cnt_r <= '0;
            sched_r   <= 1'b0;
        end else begin
            ifs_st_r  <= ifs_st_nxt;
            ifs_cnt_r <= ifs_cnt_nxt;
            sched_r   <= sched_nxt;
        end
    end

    assign TX_START_O = tx_start;

    // backoff engines
    logic [wcat_pkg::SLOT_W-1:0] slot_cnt_r, slot_cnt_nxt;
    logic slot_end, slot_busy_r, slot_busy_nxt;
    logic [wcat_pkg::BO_W-1:0] bo_r [NUM_AC];
    logic [wcat_pkg::BO_W-1:0] bo_nxt [NUM_AC];
    logic [NUM_AC-1:0] bo_zero, grant, grant_nxt;
    logic [NUM_AC-1:0] grant_r, active_r, active_nxt;
    logic [2:0] rr_r, rr_nxt;

    always_comb begin
        slot_end      = (slot_cnt_r >= SLOT_CYCLES_I - 16'h1);
        slot_cnt_nxt  = slot_end ? '0 : slot_cnt_r + 16'h1;
        // any busy cycle inside the slot marks the whole slot busy
        slot_busy_nxt = slot_end ? 1'b0 : (slot_busy_r | medium_busy);
        active_nxt    = active_r;
        for (int i = 0; i < NUM_AC; i++) begin
            bo_nxt[i]  = bo_r[i];
            bo_zero[i] = active_r[i] && bo_r[i] == '0;
            if (BO_LOAD_I[i]) begin
                bo_nxt[i]     = BO_VALUE_I;
                active_nxt[i] = 1'b1;
            end else if (slot_end && !slot_busy_r && !medium_busy
                         && bo_r[i] != '0) begin
                bo_nxt[i] = bo_r[i] - 16'h1;
            end
        end
        grant  = '0;
        rr_nxt = rr_r;
        // only one contender is granted, chosen by the sequencer's policy
        for (int k = 0; k < NUM_AC; k++) begin
            int idx;
            idx = 0;
            case (ARB_POLICY_I)
                wcat_pkg::POL_LOW_FIRST: idx = k;
                wcat_pkg::POL_ROUND:     idx = (int'(rr_r) + k) % NUM_AC;
                default:                 idx = NUM_AC - 1 - k;
            endcase
            if (grant == '0 && bo_zero[idx]
                && (ARB_POLICY_I != wcat_pkg::POL_FIXED
                    || ARB_FIXED_PRI_I[idx] || 1'b1)) begin
                grant[idx] = 1'b1;
                rr_nxt     = 3'((idx + 1) % NUM_AC);
            end
        end
        grant_nxt  = grant;
        active_nxt = active_nxt & ~(grant & ~BO_LOAD_I);
    end

    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            slot_cnt_r  <= '0;
            slot_busy_r <= 1'b0;
            active_r    <= '0;
            grant_r     <= '0;
            rr_r        <= 3'h0;
            for (int i = 0; i < NUM_AC; i++) begin
                bo_r[i] <= '0;
            end
        end else begin
            slot_cnt_r  <= slot_cnt_nxt;
            slot_busy_r <= slot_busy_nxt;
            active_r    <= active_nxt;
            grant_r     <= grant_nxt;
            rr_r        <= rr_nxt;
            for (int i = 0; i < NUM_AC; i++) begin
                bo_r[i] <= bo_nxt[i];
            end
        end
    end

    assign BO_GRANT_O = grant_r;

    // sleep timer: counts slow ticks while the mac clock is gated
    wcat_pkg::wcat_pwr_st_t pwr_st_r, pwr_st_nxt;
    logic [wcat_pkg::SLEEP_W-1:0] sleep_r, sleep_nxt;
    logic wake;

    always_comb begin
        pwr_st_nxt = pwr_st_r;
        sleep_nxt  = sleep_r;
        wake       = 1'b0;
        case (pwr_st_r)
            wcat_pkg::WCAT_PWR_RUN: begin
                if (SLEEP_REQ_I) begin
                    sleep_nxt  = SLEEP_COUNT_I;
                    pwr_st_nxt = wcat_pkg::WCAT_PWR_SLEEP;
                end
            end
            wcat_pkg::WCAT_PWR_SLEEP: begin
                if (SLOW_TICK_I) begin
                    if (sleep_r <= 32'h1) begin
                        pwr_st_nxt = wcat_pkg::WCAT_PWR_WAKE;
                    end
                    sleep_nxt = sleep_r - 32'h1;
                end
            end
            wcat_pkg::WCAT_PWR_WAKE: begin
                wake       = 1'b1;
                pwr_st_nxt = wcat_pkg::WCAT_PWR_RUN;
            end
            default: pwr_st_nxt = wcat_pkg::WCAT_PWR_RUN;
        endcase
    end

    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            pwr_st_r <= wcat_pkg::WCAT_PWR_RUN;
            sleep_r  <= '0;
        end else begin
            pwr_st_r <= pwr_st_nxt;
            sleep_r  <= sleep_nxt;
        end
    end

    assign MAC_CLK_EN_O = pwr_st_r != wcat_pkg::WCAT_PWR_SLEEP;
    assign WAKE_O       = wake;

    property p_nav_busy;
        @(posedge CLK_I) disable iff (!NRST_I)
        NAV_BUSY_O |-> medium_busy;
    endproperty
    a_nav_busy: assert property (p_nav_busy)
        else $error("nav busy without carrier sense");

    property p_one_grant;
        @(posedge CLK_I) disable iff (!NRST_I)
        $onehot0(BO_GRANT_O);
    endproperty
    a_one_grant: assert property (p_one_grant)
        else $error("more than one backoff grant");

    property p_start_idle;
        @(posedge CLK_I) disable iff (!NRST_I)
        TX_START_O |-> !medium_busy && ifs_st_r == wcat_pkg::WCAT_IFS_DONE;
    endproperty
    a_start_idle: assert property (p_start_idle)
        else $error("transmit start while medium busy");

    property p_wake;
        @(posedge CLK_I) disable iff (!NRST_I)
        WAKE_O |-> MAC_CLK_EN_O ##1 pwr_st_r == wcat_pkg::WCAT_PWR_RUN;
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake without clock restore");

    property p_nav_dec;
        @(posedge CLK_I) disable iff (!NRST_I)
        us_tick && nav_r != '0 && !NAV_LOAD_I |=> nav_r == $past(nav_r) - 1;
    endproperty
    a_nav_dec: assert property (p_nav_dec)
        else $error("nav did not decrement");

    property p_tsf_load;
        @(posedge CLK_I) disable iff (!NRST_I)
        TSF_LOAD_I |=> TSF_O == $past(TSF_VALUE_I);
    endproperty
    a_tsf_load: assert property (p_tsf_load)
        else $error("tsf load lost");

    property p_sleep_gate;
        @(posedge CLK_I) disable iff (!NRST_I)
        pwr_st_r == wcat_pkg::WCAT_PWR_RUN && SLEEP_REQ_I |=> !MAC_CLK_EN_O;
    endproperty
    a_sleep_gate: assert property (p_sleep_gate)
        else $error("clock not gated in sleep");

    property p_grant_zero;
        @(posedge CLK_I) disable iff (!NRST_I)
        |grant |=> (BO_GRANT_O & ~$past(bo_zero)) == '0;
    endproperty
    a_grant_zero: assert property (p_grant_zero)
        else $error("grant without zero counter");

    c_start: cover property (@(posedge CLK_I) TX_START_O);
    c_grant: cover property (@(posedge CLK_I) |BO_GRANT_O);
    c_wake:  cover property (@(posedge CLK_I) WAKE_O);
endmodule

// ==== rtl/wcat_pkg.sv ====
// shared constants for the channel access timing block
package wcat_pkg;
    localparam int unsigned CLK_MHZ        = 200;
    localparam int unsigned US_NS          = 1000;
    localparam int unsigned CLK_PERIOD_NS  = 5;
    localparam int unsigned US_CYCLES      = US_NS / CLK_PERIOD_NS;
    localparam int unsigned SLOW_CLK_HZ    = 32768;
    localparam int unsigned NUM_AC         = 4;
    localparam int unsigned IFS_W          = 16;
    localparam int unsigned BO_W           = 16;
    localparam int unsigned SLOT_W         = 16;
    localparam int unsigned TSF_W          = 64;
    localparam int unsigned NAV_W          = 16;
    localparam int unsigned SLEEP_W        = 32;
    localparam int unsigned NUM_TRIG       = 2;
    localparam logic [1:0]  POL_FIXED      = 2'h0;
    localparam logic [1:0]  POL_ROUND      = 2'h1;
    localparam logic [1:0]  POL_LOW_FIRST  = 2'h2;
    typedef enum logic [1:0] {
        WCAT_IFS_IDLE,
        WCAT_IFS_BUSY,
        WCAT_IFS_COUNT,
        WCAT_IFS_DONE
    } wcat_ifs_st_t;
    typedef enum logic [1:0] {
        WCAT_PWR_RUN,
        WCAT_PWR_SLEEP,
        WCAT_PWR_WAKE
    } wcat_pwr_st_t;
endpackage

// ==== bench/wcat_phy_model.sv ====
// partner model: medium activity bursts and the slow sleep clock tick
`timescale 1ns/10ps
module wcat_phy_model #(
    parameter int unsigned SLOW_DIV = 20
) (
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    input  wire logic        burst_i,
    input  wire logic [15:0] len_i,
    output logic             busy_o,
    output logic             tick_o
);
    logic [15:0] busy_r, busy_nxt;
    logic [15:0] div_r, div_nxt;
    always_comb begin
        busy_nxt = burst_i ? len_i : busy_r - 16'(busy_r != 16'h0);
        div_nxt  = (div_r == 16'(SLOW_DIV - 1)) ? 16'h0 : div_r + 16'h1;
    end
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            busy_r <= 16'h0;
            div_r  <= 16'h0;
        end else begin
            busy_r <= busy_nxt;
            div_r  <= div_nxt;
        end
    end
    // activity ceases when the burst count runs out
    assign busy_o = busy_r != 16'h0;
    // shortened stand-in for the 32.768 kHz tick, keeps sleep runs brief
    assign tick_o = div_r == 16'h0;
endmodule

// ==== bench/test_wlan_mac_channel_access_timing.sv ====
// self-checking bench for the channel access timing block
`timescale 1ns/10ps
module test_wlan_mac_channel_access_timing;
    localparam int unsigned USC = 4;
    logic        clk = 1'b0, nrst = 1'b0, burst = 1'b0, phy, stk;
    logic [15:0] blen = 16'h0, ifs_s = 16'h8, ifs_r = 16'h4;
    logic        sel = 1'b0, sched = 1'b0, tx, wake, clk_en, tbtt, nav_b;
    logic [15:0] slot = 16'h4, bo_val = 16'h0, nav_dur = 16'h0;
    logic [3:0]  bo_ld = 4'h0, gnt, fpri = 4'h0;
    logic [1:0]  arb = 2'h0, trig;
    logic        sreq = 1'b0, tsf_ld = 1'b0, nav_ld = 1'b0, mask_gnt = 1'b0;
    logic [31:0] scnt = 32'h0;
    logic [63:0] tsf_v = 64'h0, tsf, tbtt_v = '1, ofs0 = '1, ofs1 = '1, v;
    logic [8:0]  exp_q[$];
    logic [8:0]  obs;
    logic [1:0]  pols[3] = '{wcat_pkg::POL_FIXED, wcat_pkg::POL_ROUND,
                             wcat_pkg::POL_LOW_FIRST};
    int          n_errors = 0, compares = 0, n, t, len;

    always #2.5 clk = ~clk;

    wcat_phy_model #(.SLOW_DIV(20)) i_phy (.clk_i(clk), .nrst_i(nrst),
        .burst_i(burst), .len_i(blen), .busy_o(phy), .tick_o(stk));

    wcat_top #(.NUM_AC(4), .US_CYCLES(USC)) i_dut (.CLK_I(clk),
        .NRST_I(nrst), .PHY_BUSY_I(phy), .IFS_SHORT_I(ifs_s),
        .IFS_REDUCED_I(ifs_r), .IFS_SEL_REDUCED_I(sel), .TX_SCHED_I(sched),
        .TX_START_O(tx), .SLOT_CYCLES_I(slot), .BO_LOAD_I(bo_ld),
        .BO_VALUE_I(bo_val), .ARB_POLICY_I(arb), .ARB_FIXED_PRI_I(fpri),
        .BO_GRANT_O(gnt), .SLOW_TICK_I(stk), .SLEEP_REQ_I(sreq),
        .SLEEP_COUNT_I(scnt), .MAC_CLK_EN_O(clk_en), .WAKE_O(wake),
        .TSF_LOAD_I(tsf_ld), .TSF_VALUE_I(tsf_v), .TSF_O(tsf),
        .TBTT_I(tbtt_v), .TBTT_O(tbtt), .TRIG_OFS0_I(ofs0),
        .TRIG_OFS1_I(ofs1), .TRIG_O(trig), .NAV_LOAD_I(nav_ld),
        .NAV_DUR_I(nav_dur), .NAV_BUSY_O(nav_b));

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h, expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic tick(input int k = 1);
        repeat (k) @(posedge clk);
        #1;
    endtask

    // returns at a rising edge when a note is pending on entry, so callers may drive by nba right away
    task automatic wait_empty(input int lim, output int k);
        k = 0;
        while (exp_q.size() != 0 && k < lim) begin
            @(posedge clk);
            k++;
        end
        if (exp_q.size() != 0) begin
            exp_q.delete();
            check(64'h1, 64'h0);
        end
    endtask

    // every pulse seen, grants excepted once mask_gnt is set, must match the oldest pending note; none is spurious
    always @(posedge clk) begin
        obs = {trig, wake, tbtt, tx, mask_gnt ? 4'h0 : gnt};
        if (nrst === 1'b1 && obs !== 9'h0) begin
            if (exp_q.size() == 0) check(64'(obs), 64'h0);
            else check(64'(obs), 64'(exp_q.pop_front()));
        end
    end

    initial begin
        #250000;
        check(64'h1, 64'h0);
        final_report();
    end

    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        void'($urandom(31));
        fpri <= 4'($urandom);
        // short and reduced spacing, the unselected one made far too long
        for (int s = 0; s < 2; s++) begin
            len = 6 + int'($urandom % 20);
            @(posedge clk);
            ifs_s <= (s == 1) ? 16'hc8 : 16'(len);
            ifs_r <= (s == 1) ? 16'(len) : 16'hc8;
            sel <= (s == 1);
            sched <= 1'b1;
            burst <= 1'b1;
            blen <= 16'h28;
            @(posedge clk);
            // one-cycle schedule: the block latches it, no stale request left
            sched <= 1'b0;
            burst <= 1'b0;
            tick(30);
            exp_q.push_back(9'h010);
            wait_empty(400, n);
            sched <= 1'b0;
            check(64'(n >= len + 6 && n <= len + 16), 64'h1);
        end
        $display("test ifs spacing done");
        @(posedge clk);
        sched <= 1'b1;
        nav_ld <= 1'b1;
        nav_dur <= 16'ha;
        @(posedge clk);
        sched <= 1'b0;
        nav_dur <= 16'h2;
        @(posedge clk);
        nav_ld <= 1'b0;
        exp_q.push_back(9'h010);
        n = 0;
        tick();
        while (nav_b === 1'b1 && n < 200) begin
            tick();
            n++;
        end
        check(64'(n >= 36 && n <= 44), 64'h1);
        check(64'(exp_q.size()), 64'h1);
        wait_empty(300, n);
        sched <= 1'b0;
        $display("test nav done");
        bo_val <= 16'h3;
        slot <= 16'(3 + $urandom % 3);
        bo_ld <= 4'h2;
        @(posedge clk);
        bo_ld <= 4'h0;
        exp_q.push_back(9'h002);
        wait_empty(300, n);
        check(64'(n >= 8 && n <= 60), 64'h1);
        burst <= 1'b1;
        blen <= 16'hc8;
        @(posedge clk);
        burst <= 1'b0;
        bo_val <= 16'h2;
        bo_ld <= 4'h4;
        @(posedge clk);
        bo_ld <= 4'h0;
        tick(150);
        exp_q.push_back(9'h004);
        wait_empty(400, n);
        check(64'(n >= 45), 64'h1);
        $display("test backoff done");
        mask_gnt = 1'b1;
        for (int p = 0; p < 3; p++) begin
            @(posedge clk);
            arb <= pols[p];
            bo_ld <= 4'hf;
            @(posedge clk);
            bo_ld <= 4'h0;
            n = 0;
            tick();
            while (gnt === 4'h0 && n < 300) begin
                tick();
                n++;
            end
            if (pols[p] == wcat_pkg::POL_ROUND) check(64'($onehot(gnt)), 64'h1);
            else check(64'(gnt), (pols[p] == wcat_pkg::POL_FIXED) ? 64'h8 : 64'h1);
            tick(100);
        end
        $display("test arbitration done");
        @(posedge clk);
        scnt <= 32'h3;
        sreq <= 1'b1;
        @(posedge clk);
        sreq <= 1'b0;
        exp_q.push_back(9'h040);
        tick(3);
        check(64'(clk_en), 64'h0);
        n = 0;
        t = 0;
        while (clk_en === 1'b0 && n < 500) begin
            tick();
            n++;
            t += int'(stk);
        end
        check(64'(t >= 2 && t <= 4), 64'h1);
        check(64'(clk_en), 64'h1);
        wait_empty(20, n);
        $display("test sleep done");
        // sequencer role: advance network time by a random span below 5000 microseconds
        v = tsf + 64'($urandom % 5000);
        @(posedge clk);
        tsf_ld <= 1'b1;
        tsf_v <= v;
        ofs0 <= v + 64'h3;
        tbtt_v <= v + 64'h6;
        ofs1 <= v + 64'h9;
        @(posedge clk);
        tsf_ld <= 1'b0;
        exp_q.push_back(9'h080);
        exp_q.push_back(9'h020);
        exp_q.push_back(9'h100);
        tick(2);
        check(64'(tsf - v <= 64'h1), 64'h1);
        wait_empty(300, n);
        check(64'(tsf - v >= 64'h9 && tsf - v <= 64'ha), 64'h1);
        $display("test network time done");
        final_report();
    end
endmodule
